//--- logic/fsi_map.svh
// Offsets, codes and timing constants for the flash done-signal block.
// Included by the package and the modules; definitions only.
`ifndef FSI_MAP_SVH
`define FSI_MAP_SVH
`define FSI_CLK_MHZ 20
`define FSI_PULSE_NS 250
`define FSI_PULSE_CYC ((`FSI_PULSE_NS * `FSI_CLK_MHZ + 999) / 1000)
`define FSI_PSUS_MAX_US 20
`define FSI_ESUS_MAX_US 25
`define FSI_SUS_TYP_US 1
`define FSI_WBUF_TYP_US 192
`define FSI_WBUF_MAX_US 576
`define FSI_WORD_US 12
`define FSI_PSUS_CYC (`FSI_PSUS_MAX_US * `FSI_CLK_MHZ)
`define FSI_ESUS_CYC (`FSI_ESUS_MAX_US * `FSI_CLK_MHZ)
`define FSI_SUS_TYP_CYC (`FSI_SUS_TYP_US * `FSI_CLK_MHZ)
`define FSI_WBUF_TYP_CYC (`FSI_WBUF_TYP_US * `FSI_CLK_MHZ)
`define FSI_WBUF_MAX_CYC (`FSI_WBUF_MAX_US * `FSI_CLK_MHZ)
`define FSI_CMD_CFG 8'hB8
`define FSI_CODE_W 2
`define FSI_RSV_MASK 8'hFC
`define FSI_ADDR_MAKER 22'h000000
`define FSI_ADDR_PART 22'h000001
`define FSI_ADDR_PROT 16'h0002
`define FSI_ADDR_CFG 22'h000005
`define FSI_OTP_BASE 8'h80
`define FSI_OTP_LAST 8'h88
`define FSI_PROT_ON 16'h0001
`define FSI_PROT_OFF 16'h0000
`define FSI_APB_CTRL 12'h000
`define FSI_APB_STAT 12'h004
`define FSI_APB_ADDR 12'h008
`define FSI_APB_DATA 12'h00C
`define FSI_APB_PROT 12'h010
`define FSI_APB_OTP 12'h014
`endif

//--- logic/fsi_pkg.sv
// Types for the flash done-signal and identifier block.
// Assumes the map header sits beside it.
`include "fsi_map.svh"
package fsi_pkg;
  typedef enum logic [1:0] {
    FSI_BUSY_LEVEL,
    FSI_PULSE_ERASE,
    FSI_PULSE_PROG,
    FSI_PULSE_BOTH
  } fsi_mode_t;
  typedef enum logic [1:0] {
    FSI_OP_PROG,
    FSI_OP_ERASE,
    FSI_OP_WBUF
  } fsi_op_t;
endpackage

//--- logic/fsi_pulse_if.sv
// Carrier between the top and the pulse stretcher.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface fsi_pulse_if;
  logic fire;
  logic low;
  modport src (output fire, input low);
  modport gen (input fire, output low);
endinterface

//--- logic/fsi_pulse.sv
// Completion pulse stretcher for the done signal pin.
// Assumes fire pulses are single cycles on clk.
`timescale 1ns/10ps
`include "fsi_map.svh"
module fsi_pulse
  import fsi_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  fsi_pulse_if.gen pif
);
  logic [7:0] cnt;
  // Fires during a low period are dropped, never queued
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (pif.fire) begin
      cnt <= 8'(`FSI_PULSE_CYC);
    end
  end
  assign pif.low = (cnt != 8'h00);
endmodule

//--- logic/fsi_top.sv
// Done signal pin, identifier space and operation timer of the flash.
// Assumes an APB master; bus writes from the flash side arrive as pulses.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "fsi_map.svh"
module fsi_top
  import fsi_pkg::*;
#(
  parameter int unsigned WBUF_CYC = `FSI_WBUF_TYP_CYC,
  parameter int unsigned ERASE_CYC = 24000,
  parameter logic [15:0] MAKER_CODE = 16'h1234,
  parameter logic [15:0] PART_CODE = 16'h5678
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic done_signal_pin_o,
  output logic done_signal_pin_oe
);
  // MAKER_CODE and PART_CODE defaults are arbitrary
  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_SUSPENDING, ST_SUSPENDED
  } fsi_st_t;
  fsi_st_t state;
  fsi_mode_t mode;
  fsi_op_t op;
  logic cfg_armed;
  logic cfg_err;
  logic [31:0] op_cnt;
  logic [31:0] sus_cnt;
  logic [21:0] id_addr;
  logic [15:0] id_data;
  logic [63:0] prot_bits;
  logic [15:0] otp [0:8];
  logic fin_erase;
  logic fin_prog;
  fsi_pulse_if pif ();
  fsi_pulse u_pulse (.clk(clk), .sys_rst(sys_rst), .pif(pif));

  wire wr = psel && penable && pwrite;
  wire busy = (state != ST_IDLE);
  // Suspended reads as inactive on status and pin, busy for refusals
  wire active = (state == ST_RUN || state == ST_SUSPENDING);

  function automatic logic [15:0] id_lookup(input logic [21:0] a,
      input logic [63:0] pb, input fsi_mode_t m);
    logic [15:0] r;
    r = 16'h0000;
    if (a == `FSI_ADDR_MAKER) begin
      r = MAKER_CODE;
    end else if (a == `FSI_ADDR_PART) begin
      r = PART_CODE;
    end else if (a == `FSI_ADDR_CFG) begin
      r = {14'h0000, m};
    end else if (a[21:8] == 14'h0000 && a[7:0] >= `FSI_OTP_BASE &&
        a[7:0] <= `FSI_OTP_LAST) begin
      r = otp[a[3:0]];
    end else if (a[15:0] == `FSI_ADDR_PROT) begin
      r = pb[a[21:16]] ? `FSI_PROT_ON : `FSI_PROT_OFF;
    end
    return r;
  endfunction

  // Command write path over APB data register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= FSI_BUSY_LEVEL;
      cfg_armed <= 1'b0;
      cfg_err <= 1'b0;
    end else if (wr && paddr == `FSI_APB_DATA) begin
      if (cfg_armed) begin
        cfg_armed <= 1'b0;
        if ((pwdata[7:0] & `FSI_RSV_MASK) != 8'h00) begin
          cfg_err <= 1'b1;
        end else begin
          mode <= fsi_mode_t'(pwdata[`FSI_CODE_W-1:0]);
        end
      end else if (pwdata[7:0] == `FSI_CMD_CFG && !busy) begin
        cfg_armed <= 1'b1;
      end
    end else if (wr && paddr == `FSI_APB_STAT && pwdata[0]) begin
      cfg_err <= 1'b0;
    end
  end

  // Operation sequencer and suspend timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      op <= FSI_OP_PROG;
      op_cnt <= 32'h0;
      sus_cnt <= 32'h0;
      fin_erase <= 1'b0;
      fin_prog <= 1'b0;
    end else begin
      fin_erase <= 1'b0;
      fin_prog <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (wr && paddr == `FSI_APB_CTRL && pwdata[1:0] != 2'b11) begin
            op <= fsi_op_t'(pwdata[1:0]);
            op_cnt <= (pwdata[1:0] == 2'b01) ? ERASE_CYC :
                (pwdata[1:0] == 2'b10) ? WBUF_CYC :
                32'(`FSI_WORD_US * `FSI_CLK_MHZ);
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (op_cnt <= 32'h1) begin
            state <= ST_IDLE;
            fin_erase <= (op == FSI_OP_ERASE);
            fin_prog <= (op != FSI_OP_ERASE);
          end else begin
            op_cnt <= op_cnt - 32'h1;
            if (wr && paddr == `FSI_APB_CTRL && pwdata[2]) begin
              sus_cnt <= 32'(`FSI_SUS_TYP_CYC);
              state <= ST_SUSPENDING;
            end
          end
        end
        ST_SUSPENDING: begin
          if (sus_cnt <= 32'h1) begin
            state <= ST_SUSPENDED;
          end else begin
            sus_cnt <= sus_cnt - 32'h1;
          end
        end
        ST_SUSPENDED: begin
          if (wr && paddr == `FSI_APB_CTRL && pwdata[3]) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign pif.fire = (fin_erase && (mode == FSI_PULSE_ERASE ||
      mode == FSI_PULSE_BOTH)) || (fin_prog &&
      (mode == FSI_PULSE_PROG || mode == FSI_PULSE_BOTH));

  // Pin registered; open drain so only low is ever driven
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_signal_pin_oe <= 1'b0;
      done_signal_pin_o <= 1'b0;
    end else begin
      done_signal_pin_o <= 1'b0;
      if (mode == FSI_BUSY_LEVEL) begin
        done_signal_pin_oe <= active;
      end else begin
        done_signal_pin_oe <= pif.low;
      end
    end
  end

  // Protection bits and OTP store, writable for bench preload
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id_addr <= 22'h0;
      prot_bits <= 64'h0;
      for (int i = 0; i < 9; i++) begin
        otp[i] <= 16'h0000;
      end
    end else if (wr && paddr == `FSI_APB_ADDR) begin
      id_addr <= pwdata[21:0];
    end else if (wr && paddr == `FSI_APB_PROT) begin
      prot_bits[pwdata[21:16]] <= pwdata[0];
    end else if (wr && paddr == `FSI_APB_OTP && pwdata[19:16] < 4'h9) begin
      otp[pwdata[19:16]] <= pwdata[15:0];
    end
  end

  // Process form so OTP writes seen inside the lookup also wake it
  always_comb id_data = id_lookup(id_addr, prot_bits, mode);

  // APB answer, zero wait states
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > `FSI_APB_OTP;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `FSI_APB_CTRL: prdata <= {30'h0, mode};
          `FSI_APB_STAT: prdata <= {27'h0, cfg_armed, cfg_err, 
              (state == ST_SUSPENDED), (state == ST_SUSPENDING), active};
          `FSI_APB_ADDR: prdata <= {10'h0, id_addr};
          `FSI_APB_DATA: prdata <= {16'h0, id_data};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

//--- bench/fsi_top_sva.sv
// Property checker for the flash block's bus and done signal pin.
// Assumes bind onto fsi_top; one clock with a sync reset.
`timescale 1ns/10ps
module fsi_top_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic done_signal_pin_o,
  input wire logic done_signal_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_pin_never_high: assert property (
    !done_signal_pin_o) else $error("Pin driven high");
  chk_reset_pin_off: assert property (
    $fell(sys_rst) |-> !done_signal_pin_oe && !pready) else $error("Reset");
  chk_pulse_min_len: assert property (
    $rose(done_signal_pin_oe) |-> done_signal_pin_oe[*5])
    else $error("Low too short");
  chk_pulse_end_len: assert property (
    $fell(done_signal_pin_oe) |-> $past(done_signal_pin_oe, 5))
    else $error("Low cut short");
  chk_ready_after_setup: assert property (
    psel && !penable |=> pready) else $error("No ready");
  chk_ready_single: assert property (
    pready |=> !pready) else $error("Ready too long");
  chk_ready_idle_low: assert property (
    !psel |=> !pready) else $error("Stray ready");
  chk_err_unmapped: assert property (
    psel && !penable && paddr > 12'h014 |=> pslverr) else $error("No error");
  chk_err_mapped: assert property (
    psel && !penable && paddr <= 12'h014 |=> !pslverr) else $error("Error");
  chk_rdata_held: assert property (
    pready && !pwrite |=> $stable(prdata)) else $error("Read data moved");
endmodule
bind fsi_top fsi_top_sva i_fsi_top_sva (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .done_signal_pin_o(done_signal_pin_o),
  .done_signal_pin_oe(done_signal_pin_oe));

//--- bench/fsi_host.sv
// Host controller model: APB master issuing the flash block's commands.
// Assumes one shared clock; each transfer starts after a clock edge.
`timescale 1ns/10ps
`include "fsi_map.svh"
module fsi_host (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // Idle edge first, so a release and a new setup never share a step
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] code);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, `FSI_APB_DATA, 32'h000000B8, rd, err);
    xfer(1'b1, `FSI_APB_DATA, {24'h000000, code}, rd, err);
  endtask
endmodule

//--- bench/flash_sts_and_id_space_tb.sv
// Self-checking bench for the flash done-signal and identifier block.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/10ps
`include "fsi_map.svh"
module flash_sts_and_id_space_tb;
  localparam logic [15:0] MAKER = 16'hC3A1; // Arbitrary value
  localparam logic [15:0] PART = 16'h5E0D; // Arbitrary value
  localparam int ERASE_LEN = 200;
  localparam int WBUF_LEN = 10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, pin_o, pin_oe, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] otp [9];
  int failures = 0, checked = 0, cyc = 0, mode = 0, blk;
  int exp_q[$];
  always #25 clk = ~clk;
  // Erase kept long enough for a suspend to land mid-operation
  fsi_top #(.WBUF_CYC(WBUF_LEN), .ERASE_CYC(ERASE_LEN), .MAKER_CODE(MAKER),
    .PART_CODE(PART)) i_fsi_top (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .done_signal_pin_o(pin_o), .done_signal_pin_oe(pin_oe));
  fsi_host i_fsi_host (.clk(clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_fsi_host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFFFFFF);
    i_fsi_host.xfer(1'b0, a, 32'h00000000, rd, err);
    check(rd & m, e);
  endtask
  task automatic idrd(input logic [21:0] a, input logic [31:0] e);
    wr(`FSI_APB_ADDR, {10'h000, a});
    rdc(`FSI_APB_DATA, e);
  endtask
  // Model: level mode holds the pin for the whole operation, pulse modes
  // give five low cycles only for the selected kind of finish
  task automatic run_op(input int op);
    int n = 0;
    int dur;
    dur = (op == 1) ? ERASE_LEN : (op == 2) ? WBUF_LEN :
        `FSI_WORD_US * `FSI_CLK_MHZ;
    if (mode == 0) exp_q.push_back(dur);
    else exp_q.push_back(((op == 1) ? mode & 1 : mode >> 1) * 5);
    wr(`FSI_APB_CTRL, op);
    repeat (300) begin
      @(posedge clk);
      n += (pin_oe === 1'b1);
      check(pin_o, 0);
    end
    if (mode == 0) check(n, exp_q.pop_front());
    else check(n, exp_q.pop_front());
  endtask
  initial begin
    void'($urandom(32'hB00948B6));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(`FSI_APB_CTRL, 0, 32'h3);
    idrd(`FSI_ADDR_MAKER, MAKER);
    idrd(`FSI_ADDR_PART, PART);
    blk = $urandom % 64;
    wr(`FSI_APB_PROT, (blk << 16) | 1);
    idrd((blk << 16) | 2, 1);
    wr(`FSI_APB_PROT, blk << 16);
    idrd((blk << 16) | 2, 0);
    for (int i = 0; i < 9; i++) begin
      otp[i] = 16'($urandom);
      wr(`FSI_APB_OTP, (i << 16) | otp[i]);
    end
    for (int i = 0; i < 9; i++) idrd(22'h80 + i, otp[i]);
    for (int c = 0; c < 4; c++) begin
      i_fsi_host.cfg(8'(c));
      mode = c;
      rdc(`FSI_APB_CTRL, c, 32'h3);
      idrd(`FSI_ADDR_CFG, c);
      for (int op = 0; op < 3; op++) run_op(op);
    end
    i_fsi_host.cfg(8'h06);
    rdc(`FSI_APB_STAT, 32'h8, 32'h8);
    rdc(`FSI_APB_CTRL, 3, 32'h3);
    wr(`FSI_APB_STAT, 1);
    rdc(`FSI_APB_STAT, 0, 32'h8);
    for (int op = 0; op < 2; op++) begin
      wr(`FSI_APB_CTRL, op);
      i_fsi_host.cfg(8'h00);
      wr(`FSI_APB_CTRL, 4);
      repeat (400) @(posedge clk);
      rdc(`FSI_APB_STAT, 4, 32'h7);
      i_fsi_host.cfg(8'h00);
      wr(`FSI_APB_CTRL, 8);
      repeat (300) @(posedge clk);
      rdc(`FSI_APB_STAT, 0, 32'h7);
      rdc(`FSI_APB_CTRL, 3, 32'h3);
    end
    i_fsi_host.xfer(1'b0, 12'h020, 32'h00000000, rd, err);
    check(err, 1);
    test_done();
  end
endmodule
